// ### rtl/timer_prescaler_pkg.sv
// Constants for the shared timer prescaler, external clock synchroniser
// and the 16-bit timer's compare and overflow flags.
// Assumes a 32-bit classic Wishbone slave with one register per aligned word.
//
// Operation
// [RL1] Each compare match flag is set on the timer tick after the count equalled its compare value.
// [RL2] A forced compare strobe never sets a compare match flag.
// [RL3] Every flag clears when its interrupt vector runs or when software writes a one to it.
// [RL4] The overflow flag is set on overflow in normal and clear-on-compare modes, else per mode.
// [RL5] Both timers share one prescaler with their own clock selects, and select 1 is the undivided clock.
// [RL6] The prescaler offers taps dividing the system clock by 8, 64, 256 and 1024.
// [RL7] The prescaler runs freely, so the first prescaled tick comes 1 to N+1 cycles after enabling.
// [RL8] The external clock pin is sampled every cycle by a high-phase latch, rising-edge flops and an edge detector.
// [RL9] Select 7 counts rising external edges and select 6 counts falling ones.
// [RL10] An external edge reaches the counter after 2.5 to 3.5 system cycles.
// [RL11] Software switches the external clock on or off only while the pin has been stable one cycle.
// [RL12] The external clock keeps each half period longer than one system cycle.
// [RL13] External pin edges go straight to the timer and never through the prescaler divider.
// [RL14] With sync hold mode set the prescaler reset bit keeps its value, and clearing the mode clears it.
// [RL15] Writing one to the prescaler reset bit resets the prescaler, and hardware clears it next unless held.
// [RL16] A flag set by hardware wins over a clear in the same cycle.
// [RL17] Select 0 stops the timer and selects 2 to 5 pick the taps in increasing divisor order.

package timer_prescaler_pkg;

    // ----------------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------------
    localparam logic [7:0] ADDR_GENERAL_TIMER_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_TIMER1_INTERRUPT_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_TIMER1_INTERRUPT_MASK = 8'h0c;

    // ----------------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------------
    localparam int BIT_SYNC_HOLD_MODE = 7;
    localparam int BIT_PRESCALER_RESET = 0;
    localparam int BIT_COMPARE_B_FLAG = 2;
    localparam int BIT_COMPARE_A_FLAG = 1;
    localparam int BIT_OVERFLOW_FLAG = 0;
    localparam int LSB_CLOCK_SELECT_T0 = 0;
    localparam int LSB_CLOCK_SELECT_T1 = 4;
    localparam logic [7:0] FLAG_MASK = 8'h07;

    // ----------------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------------
    localparam logic [2:0] RESET_CLOCK_SELECT = 3'h0;
    localparam logic [2:0] RESET_FLAGS = 3'h0;
    localparam logic [2:0] RESET_MASK = 3'h0;
    localparam logic RESET_SYNC_HOLD = 1'b0;
    localparam logic RESET_PRESCALER_BIT = 1'b0;

    // ----------------------------------------------------------------------
    // Clock source select codes
    // ----------------------------------------------------------------------
    typedef enum logic [2:0] {
        CS_STOPPED = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } clock_source_type;

    // ----------------------------------------------------------------------
    // Prescaler divisors and waveform modes
    // ----------------------------------------------------------------------
    localparam int PRESCALER_WIDTH = 10;
    // Divisors are one bit wider than the counter so that 1024 fits.
    localparam logic [10:0] DIVISOR_8 = 11'h008;
    localparam logic [10:0] DIVISOR_64 = 11'h040;
    localparam logic [10:0] DIVISOR_256 = 11'h100;
    localparam logic [10:0] DIVISOR_1024 = 11'h400;
    localparam logic [3:0] WGM_NORMAL = 4'h0;
    localparam logic [3:0] WGM_CTC_COMPARE_A = 4'h4;
    localparam logic [3:0] WGM_CTC_CAPTURE = 4'hc;

endpackage

// ### rtl/ext_clock_sync.sv
// External timer clock pin synchroniser and edge detector.
// Assumes the pin is an ordinary asynchronous input and clk_sys is free running.

`timescale 1ns/1ps

module ext_clock_sync
(
    input wire logic clk_sys, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic clockEnable, // Freezes all state while low.
    input wire logic extPin, // External timer clock pin.
    output logic riseEdge, // High for one cycle after a rising edge.
    output logic fallEdge // High for one cycle after a falling edge.
);

    logic lowPhase;
    logic synced;
    logic previous;

    // ----------------------------------------------------------------------
    // Sampling
    // ----------------------------------------------------------------------

    // A falling-edge flop stands in for the latch that is transparent while the
    // clock is high: it holds what the latch held when it closed.
    always_ff @(negedge clk_sys or posedge rst)
    begin
        if (rst)
            lowPhase <= 1'b0;
        else if (clockEnable)
            lowPhase <= extPin; // RL8
    end

    // Rising-edge flops; only the second stage and the detector look further.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            synced <= 1'b0;
            previous <= 1'b0;
        end
        else if (clockEnable)
        begin
            synced <= lowPhase; // RL8
            previous <= synced;
        end
    end

    // Edge detector; the pin must stay steady over a full cycle to be seen.
    always_comb
    begin
        riseEdge = synced & ~previous; // RL9
        fallEdge = ~synced & previous; // RL9
    end

endmodule

// ### rtl/timer_prescaler_ext_clock_sync.sv
// Shared timer prescaler, external clock pin handling, prescaler reset with
// sync hold mode, and the 16-bit timer's compare and overflow flags.
// Assumes the counting and waveform logic sits outside and consumes the tick
// outputs, and that software reaches the registers over classic Wishbone.
//
// Our own choices: the Wishbone interface to the registers and the register offsets.

`timescale 1ns/1ps

module timer_prescaler_ext_clock_sync
(
    input wire logic clk_sys, // System clock, 50 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic clockEnable, // Freezes all state while low.
    // Wishbone slave.
    input wire logic wb_cyc_i, // Bus cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic wb_we_i, // Write enable.
    input wire logic [7:0] wb_adr_i, // Byte address.
    input wire logic [3:0] wb_sel_i, // Byte lane selects.
    input wire logic [31:0] wb_dat_i, // Write data.
    output logic [31:0] wb_dat_o, // Read data.
    output logic wb_ack_o, // Acknowledge.
    // External clock pins.
    input wire logic extTimer0ClockPin, // Timer 0 external clock pin.
    input wire logic extTimer1ClockPin, // Timer 1 external clock pin.
    // Timer 1 counter status.
    input wire logic [15:0] timerCountValue, // Timer 1 count.
    input wire logic [15:0] compareAValue, // Timer 1 compare A.
    input wire logic [15:0] compareBValue, // Timer 1 compare B.
    input wire logic [3:0] waveformModeSelect, // Timer 1 waveform mode.
    input wire logic overflowEvent, // Counter wraps on this tick.
    input wire logic modeOverflowEvent, // Mode-specific overflow point.
    input wire logic [2:0] vectorTaken, // Vector executed pulses, flag layout.
    // Outputs.
    output logic timer0Tick, // Timer 0 count enable pulse.
    output logic timer1Tick, // Timer 1 count enable pulse.
    output logic [2:0] interruptFlags, // Sticky flags: B, A, overflow.
    output logic irq // Level interrupt.
);

    // ----------------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------------
    logic [timer_prescaler_pkg::PRESCALER_WIDTH-1:0] prescaleCount;
    logic [timer_prescaler_pkg::PRESCALER_WIDTH-1:0] next_prescaleCount;
    logic syncHoldMode;
    logic next_syncHoldMode;
    logic prescalerReset;
    logic next_prescalerReset;
    logic [2:0] clockSelect0;
    logic [2:0] next_clockSelect0;
    logic [2:0] clockSelect1;
    logic [2:0] next_clockSelect1;
    logic [2:0] flags;
    logic [2:0] next_flags;
    logic [2:0] mask;
    logic [2:0] next_mask;
    logic next_timer0Tick;
    logic next_timer1Tick;
    logic next_irq;
    logic next_ack;
    logic [31:0] next_datOut;
    logic busWrite;
    logic lane0Write;
    logic [3:0] tapTick;
    logic rise0;
    logic fall0;
    logic rise1;
    logic fall1;

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------

    // Tap tick: high in the last count of each period of the given divisor.
    function automatic logic tapAt(
        input logic [timer_prescaler_pkg::PRESCALER_WIDTH-1:0] count,
        input logic [timer_prescaler_pkg::PRESCALER_WIDTH:0] divisor
    );
        logic [timer_prescaler_pkg::PRESCALER_WIDTH:0] wideMask;
        logic [timer_prescaler_pkg::PRESCALER_WIDTH-1:0] lowMask;
        wideMask = divisor - 11'h001;
        lowMask = wideMask[timer_prescaler_pkg::PRESCALER_WIDTH-1:0];
        tapAt = (count & lowMask) == lowMask;
    endfunction

    // Tick for one timer from its clock select; edges bypass the divider.
    function automatic logic selectTick(
        input logic [2:0] select,
        input logic [3:0] taps,
        input logic rise,
        input logic fall
    );
        logic tick;
        tick = 1'b0;
        unique case (timer_prescaler_pkg::clock_source_type'(select))
            timer_prescaler_pkg::CS_STOPPED: tick = 1'b0; // RL17
            timer_prescaler_pkg::CS_DIV1: tick = 1'b1; // RL5
            timer_prescaler_pkg::CS_DIV8: tick = taps[0]; // RL17
            timer_prescaler_pkg::CS_DIV64: tick = taps[1];
            timer_prescaler_pkg::CS_DIV256: tick = taps[2];
            timer_prescaler_pkg::CS_DIV1024: tick = taps[3];
            timer_prescaler_pkg::CS_EXT_FALL: tick = fall; // RL9 RL13
            timer_prescaler_pkg::CS_EXT_RISE: tick = rise; // RL9 RL13
        endcase
        selectTick = tick;
    endfunction

    // ----------------------------------------------------------------------
    // External clock synchronisers
    // ----------------------------------------------------------------------

    // One synchroniser per pin; their edge pulses feed the tick flops below,
    // so an edge reaches the counter 2.5 to 3.5 cycles after the pin moved.
    ext_clock_sync sync0 // RL10
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .clockEnable(clockEnable),
        .extPin(extTimer0ClockPin),
        .riseEdge(rise0),
        .fallEdge(fall0)
    );

    ext_clock_sync sync1
    (
        .clk_sys(clk_sys),
        .rst(rst),
        .clockEnable(clockEnable),
        .extPin(extTimer1ClockPin),
        .riseEdge(rise1),
        .fallEdge(fall1)
    );

    // ----------------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------------

    // A write takes effect on the edge where the master sees ack high.
    always_comb
    begin
        busWrite = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
        lane0Write = busWrite & wb_sel_i[0];
    end

    // ----------------------------------------------------------------------
    // Prescaler and its reset control
    // ----------------------------------------------------------------------

    // The counter runs regardless of any clock select, so a freshly enabled
    // tap may tick after anything from 1 to N+1 cycles.
    always_comb
    begin
        next_syncHoldMode = syncHoldMode;
        next_prescalerReset = prescalerReset;
        if (lane0Write && wb_adr_i == timer_prescaler_pkg::ADDR_GENERAL_TIMER_CONTROL)
        begin
            next_syncHoldMode = wb_dat_i[timer_prescaler_pkg::BIT_SYNC_HOLD_MODE];
            next_prescalerReset = wb_dat_i[timer_prescaler_pkg::BIT_PRESCALER_RESET]
                & wb_dat_i[timer_prescaler_pkg::BIT_SYNC_HOLD_MODE]; // RL14 RL15
            if (wb_dat_i[timer_prescaler_pkg::BIT_PRESCALER_RESET])
                next_prescaleCount = '0; // RL15
            else
                next_prescaleCount = prescaleCount + 10'h001; // RL7
        end
        else
        begin
            if (!syncHoldMode)
                next_prescalerReset = 1'b0; // RL14 RL15
            if (prescalerReset)
                next_prescaleCount = '0; // RL14
            else
                next_prescaleCount = prescaleCount + 10'h001; // RL7
        end
    end

    // Taps of the shared divider, silenced while the reset bit holds it.
    always_comb
    begin
        tapTick[0] = tapAt(prescaleCount, timer_prescaler_pkg::DIVISOR_8); // RL6
        tapTick[1] = tapAt(prescaleCount, timer_prescaler_pkg::DIVISOR_64); // RL6
        tapTick[2] = tapAt(prescaleCount, timer_prescaler_pkg::DIVISOR_256); // RL6
        tapTick[3] = tapAt(prescaleCount, timer_prescaler_pkg::DIVISOR_1024); // RL6
    end

    // ----------------------------------------------------------------------
    // Timer ticks
    // ----------------------------------------------------------------------

    // Each timer keeps its own select over the one shared divider. While the
    // reset bit is held both timers stay halted so they can be set up safely.
    always_comb
    begin
        next_timer0Tick = selectTick(clockSelect0, tapTick, rise0, fall0)
            & ~prescalerReset; // RL5 RL14
        next_timer1Tick = selectTick(clockSelect1, tapTick, rise1, fall1)
            & ~prescalerReset; // RL5 RL14
    end

    // ----------------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------------

    // Clock selects and interrupt mask; only byte lane 0 carries data.
    always_comb
    begin
        next_clockSelect0 = clockSelect0;
        next_clockSelect1 = clockSelect1;
        next_mask = mask;
        if (lane0Write && wb_adr_i == timer_prescaler_pkg::ADDR_CLOCK_SELECT)
        begin
            next_clockSelect0 = wb_dat_i[timer_prescaler_pkg::LSB_CLOCK_SELECT_T0 +: 3];
            next_clockSelect1 = wb_dat_i[timer_prescaler_pkg::LSB_CLOCK_SELECT_T1 +: 3];
        end
        if (lane0Write && wb_adr_i == timer_prescaler_pkg::ADDR_TIMER1_INTERRUPT_MASK)
            next_mask = wb_dat_i[2:0];
    end

    // ----------------------------------------------------------------------
    // Timer 1 flags
    // ----------------------------------------------------------------------

    // A match seen on a tick sets its flag on that tick, which is the timer
    // cycle after the count held the matching value. Forced compare strobes
    // never reach this logic, so they cannot set a flag.
    always_comb
    begin
        logic [2:0] setBits;
        logic [2:0] clearBits;
        logic normalOrCtc;
        setBits = 3'h0;
        clearBits = vectorTaken; // RL3
        normalOrCtc = waveformModeSelect == timer_prescaler_pkg::WGM_NORMAL
            || waveformModeSelect == timer_prescaler_pkg::WGM_CTC_COMPARE_A
            || waveformModeSelect == timer_prescaler_pkg::WGM_CTC_CAPTURE;
        if (timer1Tick)
        begin
            setBits[timer_prescaler_pkg::BIT_COMPARE_A_FLAG] =
                timerCountValue == compareAValue; // RL1 RL2
            setBits[timer_prescaler_pkg::BIT_COMPARE_B_FLAG] =
                timerCountValue == compareBValue; // RL1 RL2
            setBits[timer_prescaler_pkg::BIT_OVERFLOW_FLAG] =
                normalOrCtc ? overflowEvent : modeOverflowEvent; // RL4
        end
        if (lane0Write && wb_adr_i == timer_prescaler_pkg::ADDR_TIMER1_INTERRUPT_FLAGS)
            clearBits = clearBits | wb_dat_i[2:0]; // RL3
        next_flags = (flags & ~clearBits) | setBits; // RL16
        next_irq = |(next_flags & next_mask);
    end

    // ----------------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------------

    // Ack comes one cycle after the request and drops the cycle after, so
    // back-to-back requests cost two cycles each. Unmapped reads give zero.
    always_comb
    begin
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_datOut = 32'h0000_0000;
        if (next_ack && !wb_we_i)
        begin
            unique case (wb_adr_i)
                timer_prescaler_pkg::ADDR_GENERAL_TIMER_CONTROL:
                begin
                    next_datOut[timer_prescaler_pkg::BIT_SYNC_HOLD_MODE] = syncHoldMode;
                    next_datOut[timer_prescaler_pkg::BIT_PRESCALER_RESET] = prescalerReset;
                end
                timer_prescaler_pkg::ADDR_CLOCK_SELECT:
                begin
                    next_datOut[timer_prescaler_pkg::LSB_CLOCK_SELECT_T0 +: 3] = clockSelect0;
                    next_datOut[timer_prescaler_pkg::LSB_CLOCK_SELECT_T1 +: 3] = clockSelect1;
                end
                timer_prescaler_pkg::ADDR_TIMER1_INTERRUPT_FLAGS:
                    next_datOut[2:0] = flags;
                timer_prescaler_pkg::ADDR_TIMER1_INTERRUPT_MASK:
                    next_datOut[2:0] = mask;
                default:
                    next_datOut = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------------

    // All state is frozen while the clock enable is low.
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            prescaleCount <= '0;
            syncHoldMode <= timer_prescaler_pkg::RESET_SYNC_HOLD;
            prescalerReset <= timer_prescaler_pkg::RESET_PRESCALER_BIT;
            clockSelect0 <= timer_prescaler_pkg::RESET_CLOCK_SELECT;
            clockSelect1 <= timer_prescaler_pkg::RESET_CLOCK_SELECT;
            flags <= timer_prescaler_pkg::RESET_FLAGS;
            mask <= timer_prescaler_pkg::RESET_MASK;
            timer0Tick <= 1'b0;
            timer1Tick <= 1'b0;
            irq <= 1'b0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (clockEnable)
        begin
            prescaleCount <= next_prescaleCount;
            syncHoldMode <= next_syncHoldMode;
            prescalerReset <= next_prescalerReset;
            clockSelect0 <= next_clockSelect0;
            clockSelect1 <= next_clockSelect1;
            flags <= next_flags;
            mask <= next_mask;
            timer0Tick <= next_timer0Tick;
            timer1Tick <= next_timer1Tick;
            irq <= next_irq;
            wb_ack_o <= next_ack;
            wb_dat_o <= next_datOut;
        end
    end

    // Flags are shown directly for the counter core and vector logic.
    always_comb
    begin
        interruptFlags = flags;
    end

endmodule

// ### tb/timer_prescaler_monitor.sv
// Concurrent checks on the ports of the prescaler and flag block.
// Assumes it is bound into the top module; flag checks pause while clockEnable is low.
`timescale 1ns/1ps
module timer_prescaler_monitor
(
    input wire logic clk_sys, // Clock.
    input wire logic rst, // Reset.
    input wire logic clockEnable, // Clock enable.
    input wire logic wb_cyc_i, // Cycle.
    input wire logic wb_stb_i, // Strobe.
    input wire logic [31:0] wb_dat_o, // Read data.
    input wire logic wb_ack_o, // Acknowledge.
    input wire logic [15:0] timerCountValue, // Count.
    input wire logic [15:0] compareAValue, // Compare A.
    input wire logic [15:0] compareBValue, // Compare B.
    input wire logic [3:0] waveformModeSelect, // Mode.
    input wire logic overflowEvent, // Wrap.
    input wire logic [2:0] vectorTaken, // Vector pulses.
    input wire logic timer1Tick, // Tick.
    input wire logic [2:0] interruptFlags, // Flags.
    input wire logic irq // Interrupt.
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic hitA;
    logic hitB;
    logic wrapSet;
    // Flag causes; overflow only counts in the modes that wrap plainly.
    assign hitA = clockEnable && timer1Tick && (timerCountValue == compareAValue);
    assign hitB = clockEnable && timer1Tick && (timerCountValue == compareBValue);
    assign wrapSet = clockEnable && timer1Tick && overflowEvent && (waveformModeSelect inside
        {timer_prescaler_pkg::WGM_NORMAL, timer_prescaler_pkg::WGM_CTC_COMPARE_A,
        timer_prescaler_pkg::WGM_CTC_CAPTURE});
    AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    AST_DATA_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_A_SET: assert property (hitA |=> interruptFlags[1])
        else $error("compare A flag not set");
    AST_B_SET: assert property (hitB |=> interruptFlags[2])
        else $error("compare B flag not set");
    AST_A_CAUSE: assert property ($rose(interruptFlags[1]) |-> $past(hitA))
        else $error("compare A flag set without match");
    AST_OVF_SET: assert property (wrapSet |=> interruptFlags[0])
        else $error("overflow flag not set");
    AST_VEC_CLR: assert property (clockEnable && vectorTaken[1] && !hitA
        |=> !interruptFlags[1])
        else $error("vector did not clear flag");
    AST_IRQ_QUIET: assert property (interruptFlags == 3'h0 |-> !irq) else $error("stray irq");
endmodule
bind timer_prescaler_ext_clock_sync timer_prescaler_monitor u_timer_prescaler_monitor (.clk_sys,
    .rst, .clockEnable, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .timerCountValue,
    .compareAValue,
    .compareBValue, .waveformModeSelect, .overflowEvent, .vectorTaken, .timer1Tick,
    .interruptFlags, .irq);

// ### tb/ext_clock_source.sv
// Model of the clock source on the external timer clock pins.
// Assumes a start pulse per frame; the pin rests low between frames.
`timescale 1ns/1ps
module ext_clock_source
#(
    parameter int HALF_NS = 70,
    parameter int EDGES = 8
)
(
    input wire logic start, // Begins a frame.
    output logic pin // Clock pin.
);
    // Each half period spans 3.5 system cycles, so no edge is missed.
    initial pin = 1'b0;
    // A quarter-period offset keeps every pin edge away from both clock edges,
    // so the falling-edge capture flop never races the pin.
    always @(posedge start)
    begin
        #5;
        repeat (EDGES)
        begin
            #HALF_NS pin = 1'b1;
            #HALF_NS pin = 1'b0;
        end
    end
endmodule

// ### tb/timer_prescaler_ext_clock_sync_tb.sv
// Self-checking bench for the prescaler, external clock and flags.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module timer_prescaler_ext_clock_sync_tb;
    typedef struct {logic [2:0] sel; int len; int exp;} row_type;
    logic clk_sys = 0, rst = 1, cyc = 0, stb = 0, we = 0, start = 0, ovf = 0, ce = 1;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic ack, pin, t0, t1, irq;
    logic [15:0] cnt = 0, cmpA = 16'h0001, cmpB = 16'h0002;
    logic [3:0] wgm = 0;
    logic [2:0] vec = 0, flags;
    int failCount = 0, nCompared = 0, cycles = 0, n0, n1;
    row_type rows[8] = '{'{3'h1, 2048, 2048}, '{3'h2, 2048, 256}, '{3'h3, 2048, 32},
        '{3'h4, 2048, 8}, '{3'h5, 2048, 2}, '{3'h0, 80, 0}, '{3'h6, 80, 8}, '{3'h7, 80, 8}};
    timer_prescaler_ext_clock_sync u_timer_prescaler_ext_clock_sync (.clk_sys(clk_sys),
        .rst(rst), .clockEnable(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .extTimer0ClockPin(pin), .extTimer1ClockPin(pin), .timerCountValue(cnt),
        .compareAValue(cmpA), .compareBValue(cmpB), .waveformModeSelect(wgm),
        .overflowEvent(ovf), .modeOverflowEvent(1'b0), .vectorTaken(vec),
        .timer0Tick(t0), .timer1Tick(t1), .interruptFlags(flags), .irq(irq));
    ext_clock_source u_ext_clock_source (.start(start), .pin(pin));
    always #10 clk_sys = ~clk_sys;
    // Cuts a hang short well past the expected run length.
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failCount++;
            summarize();
        end
    end
    // ----------------------------------------------------------------
    // Bus cycle, comparison and closing tasks
    // ----------------------------------------------------------------
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
            failCount++;
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic summarize();
        $display("compared %0d mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Reset, table of clock sources, then hold, flags and overflow cases.
    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a <= 16; a += 4) rd(8'(a), 32'h0);
        foreach (rows[i])
        begin
            wb(1'b1, 8'h04, {25'h0, rows[i].sel, 1'b0, rows[i].sel});
            repeat (3) @(posedge clk_sys);
            start <= 1'b1;
            n0 = 0; n1 = 0;
            repeat (rows[i].len)
            begin
                @(posedge clk_sys);
                start <= 1'b0;
                n0 += t0; n1 += t1;
            end
            chk(n0, rows[i].exp);
            chk(n1, rows[i].exp);
        end
        wb(1'b1, 8'h04, 32'h11);
        wb(1'b1, 8'h00, 32'h81);
        rd(8'h00, 32'h81);
        n1 = 0;
        repeat (40) begin @(posedge clk_sys); n1 += t1; end
        chk(n1, 0);
        wb(1'b1, 8'h00, 32'h0);
        rd(8'h00, 32'h0);
        wb(1'b1, 8'h00, 32'h1);
        rd(8'h00, 32'h0);
        wb(1'b1, 8'h10, 32'hff);
        rd(8'h10, 32'h0);
        wb(1'b1, 8'h0c, 32'h2);
        cmpA <= 16'h0;
        rd(8'h08, 32'h2);
        chk(irq, 1'b1);
        wb(1'b1, 8'h08, 32'h2);
        rd(8'h08, 32'h2);
        cmpA <= 16'h1;
        wb(1'b1, 8'h08, 32'h2);
        rd(8'h08, 32'h0);
        chk(irq, 1'b0);
        // A match seen while the clock enable is low must not set the flag.
        ce <= 1'b0;
        cmpA <= 16'h0;
        repeat (4) @(posedge clk_sys);
        chk(flags, 32'h0);
        ce <= 1'b1;
        @(posedge clk_sys) cmpA <= 16'h1;
        @(posedge clk_sys) vec <= 3'h2;
        @(posedge clk_sys) vec <= 3'h0;
        rd(8'h08, 32'h0);
        // A one-tick match and a vector clear in the same cycle: the set must win.
        cmpA <= 16'h0;
        vec <= 3'h2;
        @(posedge clk_sys);
        cmpA <= 16'h1;
        vec <= 3'h0;
        rd(8'h08, 32'h2);
        wb(1'b1, 8'h08, 32'h2);
        wgm <= 4'h1; ovf <= 1'b1;
        @(posedge clk_sys) ovf <= 1'b0;
        rd(8'h08, 32'h0);
        wgm <= 4'h4; ovf <= 1'b1;
        @(posedge clk_sys) ovf <= 1'b0;
        rd(8'h08, 32'h1);
        summarize();
    end
endmodule
